// ==== hdl/tat_pkg.sv ====
// Constants, field layout and types of the type A timer.
// Assumes one 200 MHz clock and a 32-bit APB register slave.
//
// Contract
// - Enable bit runs the timer, clear stops counting
// - Stop-in-idle halts the timer during Idle mode
// - Write-disable ignores counter writes while one pends
// - Write-pending bit reads 1 only in async mode
// - Gate accumulation works only with internal clock
// - Prescale codes divide by 1, 8, 64, 256
// - Aliases at +4/+8/+c clear, set, invert bits; status writes at any alias clear bits
// - Unimplemented bits read zero, writes ignored
package tat_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [15:0] TAT_ADDR_CTRL   = 16'h0600;
	localparam logic [15:0] TAT_ADDR_COUNT  = 16'h0610;
	localparam logic [15:0] TAT_ADDR_PERIOD = 16'h0620;
	localparam logic [15:0] TAT_ADDR_STATUS = 16'h0630;
	localparam logic [15:0] TAT_ADDR_MASK   = 16'h0640;

	localparam logic [15:0] TAT_RST_CTRL   = 16'h0000;
	localparam logic [15:0] TAT_RST_COUNT  = 16'h0000;
	localparam logic [15:0] TAT_RST_PERIOD = 16'hffff;
	localparam logic [15:0] TAT_RST_STATUS = 16'h0000;
	localparam logic [15:0] TAT_RST_MASK   = 16'h0000;

	// Writable control bits; the rest stay zero
	localparam logic [15:0] TAT_CTRL_WMASK = 16'hb0b6;
	localparam logic [15:0] TAT_IRQ_WMASK  = 16'h0001;

	// ---------------------------------------------------------------
	// Control field positions
	// ---------------------------------------------------------------
	localparam int TAT_BIT_ON    = 15;
	localparam int TAT_BIT_STOP_IN_IDLE  = 13;
	localparam int TAT_BIT_WDIS  = 12;
	localparam int TAT_BIT_WIP   = 11;
	localparam int TAT_BIT_GATE  = 7;
	localparam int TAT_BIT_PSHI  = 5;
	localparam int TAT_BIT_PSLO  = 4;
	localparam int TAT_BIT_SYNC  = 2;
	localparam int TAT_BIT_CSRC  = 1;
	localparam int TAT_BIT_MATCH = 0;

	// ---------------------------------------------------------------
	// Alias kinds, taken from address bits 3:2
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TAT_AL_WRITE = 2'b00,
		TAT_AL_CLEAR = 2'b01,
		TAT_AL_SET   = 2'b10,
		TAT_AL_INV   = 2'b11
	} tat_alias_e;

	// Prescaler terminal counts, one less than the divide ratio
	localparam logic [7:0] TAT_PS_TERM1   = 8'h00;
	localparam logic [7:0] TAT_PS_TERM8   = 8'h07;
	localparam logic [7:0] TAT_PS_TERM64  = 8'h3f;
	localparam logic [7:0] TAT_PS_TERM256 = 8'hff;

	typedef struct packed {
		logic       on;
		logic       stop_in_idle;
		logic       async_write_disable;
		logic       gate_accumulate_enable;
		logic [1:0] prescale_select;
		logic       external_clock_sync;
		logic       clock_source_select;
	} tat_ctrl_s;

	function automatic logic [15:0] tat_alias(input logic [15:0] old, input logic [15:0] wd,
		input tat_alias_e kind);
		case (kind)
			TAT_AL_CLEAR: tat_alias = old & ~wd;
			TAT_AL_SET:   tat_alias = old | wd;
			TAT_AL_INV:   tat_alias = old ^ wd;
			default:      tat_alias = wd;
		endcase
	endfunction

endpackage

// ==== hdl/tat_prescale.sv ====
// Input clock prescaler of the type A timer.
// Assumes in_tick and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tat_prescale (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	// Ticks
	input  wire logic       in_tick,
	output logic            out_tick
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [7:0] term;

	// ---------------------------------------------------------------
	// Divider
	// ---------------------------------------------------------------
	always_comb begin
		case (sel)
			2'b01:   term = tat_pkg::TAT_PS_TERM8;
			2'b10:   term = tat_pkg::TAT_PS_TERM64;
			2'b11:   term = tat_pkg::TAT_PS_TERM256;
			default: term = tat_pkg::TAT_PS_TERM1;
		endcase
		out_tick = in_tick && (cnt_ff >= term);
		nxt_cnt  = cnt_ff;
		if (clear) begin
			nxt_cnt = 8'h00;
		end else if (out_tick) begin
			nxt_cnt = 8'h00;
		end else if (in_tick) begin
			nxt_cnt = cnt_ff + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	a_ps_clear_hold: assert property (@(posedge clk) disable iff (!rst_n)
		clear |=> (cnt_ff == 8'h00))
		else $error("prescaler not held cleared");

	a_ps_ratio: assert property (@(posedge clk) disable iff (!rst_n)
		out_tick |-> (in_tick && cnt_ff == term))
		else $error("prescaler ticked at wrong count");

endmodule // tat_prescale
`default_nettype wire

// ==== hdl/tat_top.sv ====
// Type A timer with its APB register slave and interrupt.
// Assumes an APB master on clk; gate and external clock are raw pins.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tat_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Device state and pins
	input  wire logic        idle_mode,
	input  wire logic        gate_pin,
	input  wire logic        ext_clk_pin,
	// Interrupt
	output logic             irq
);
	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_s1_ff;
	logic rst_n_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff  <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff  <= rst_s1_ff;
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] pin_s1_ff;
	logic [1:0] pin_s2_ff;
	logic       ext_prev_ff;
	logic       ext_rise;
	logic       gate_lvl;

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			pin_s1_ff   <= 2'b00;
			pin_s2_ff   <= 2'b00;
			ext_prev_ff <= 1'b0;
		end else begin
			pin_s1_ff   <= {ext_clk_pin, gate_pin};
			pin_s2_ff   <= pin_s1_ff;
			ext_prev_ff <= pin_s2_ff[1];
		end
	end

	assign ext_rise = pin_s2_ff[1] && !ext_prev_ff;
	assign gate_lvl = pin_s2_ff[0];

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [15:0]       ctrl_ff;
	logic [15:0]       cnt_ff;
	logic [15:0]       per_ff;
	logic [15:0]       stat_ff;
	logic [15:0]       mask_ff;
	logic              pend_ff;
	logic [15:0]       pend_val_ff;
	logic [31:0]       prdata_ff;
	logic              pslverr_ff;
	logic [15:0]       nxt_ctrl;
	logic [15:0]       nxt_cnt;
	logic [15:0]       nxt_per;
	logic [15:0]       nxt_stat;
	logic [15:0]       nxt_mask;
	logic              nxt_pend;
	logic [15:0]       nxt_pend_val;
	logic [31:0]       nxt_prdata;
	logic              nxt_pslverr;
	tat_pkg::tat_ctrl_s ctrl;

	assign ctrl.on                     = ctrl_ff[tat_pkg::TAT_BIT_ON];
	assign ctrl.stop_in_idle           = ctrl_ff[tat_pkg::TAT_BIT_STOP_IN_IDLE];
	assign ctrl.async_write_disable    = ctrl_ff[tat_pkg::TAT_BIT_WDIS];
	assign ctrl.gate_accumulate_enable = ctrl_ff[tat_pkg::TAT_BIT_GATE];
	assign ctrl.prescale_select        = ctrl_ff[tat_pkg::TAT_BIT_PSHI:tat_pkg::TAT_BIT_PSLO];
	assign ctrl.external_clock_sync    = ctrl_ff[tat_pkg::TAT_BIT_SYNC];
	assign ctrl.clock_source_select    = ctrl_ff[tat_pkg::TAT_BIT_CSRC];

	// ---------------------------------------------------------------
	// Count source, gating and prescale
	// ---------------------------------------------------------------
	logic async_mode;
	logic run_en;
	logic pre_in;
	logic count_tick;
	logic wip_rd;

	// Async mode: external clock counted, count writes held until its next rising edge
	assign async_mode = ctrl.clock_source_select && !ctrl.external_clock_sync;
	assign run_en     = ctrl.on && !(ctrl.stop_in_idle && idle_mode);
	assign wip_rd     = pend_ff && async_mode;

	always_comb begin
		if (ctrl.clock_source_select) begin
			pre_in = ext_rise;
		end else if (ctrl.gate_accumulate_enable) begin
			pre_in = gate_lvl;
		end else begin
			pre_in = 1'b1;
		end
	end

	tat_prescale u_prescale (
		.clk      (clk),
		.rst_n    (rst_n_ff),
		.clear    (!run_en),
		.sel      (ctrl.prescale_select),
		.in_tick  (pre_in && run_en),
		.out_tick (count_tick)
	);

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	logic                 acc;
	logic                 wr;
	logic                 hit;
	logic [15:0]          base;
	logic [15:0]          wd;
	tat_pkg::tat_alias_e  kind;
	logic                 cnt_wr;
	logic                 cnt_take;
	logic                 apply;

	assign base   = {paddr[15:4], 4'h0};
	assign kind   = tat_pkg::tat_alias_e'(paddr[3:2]);
	assign wd     = pwdata[15:0];
	assign hit    = (paddr[1:0] == 2'b00) && ((base == tat_pkg::TAT_ADDR_CTRL)
		|| (base == tat_pkg::TAT_ADDR_COUNT) || (base == tat_pkg::TAT_ADDR_PERIOD)
		|| (base == tat_pkg::TAT_ADDR_STATUS) || (base == tat_pkg::TAT_ADDR_MASK));
	assign acc    = psel && penable;
	assign wr     = acc && pwrite && hit;
	assign cnt_wr = wr && (base == tat_pkg::TAT_ADDR_COUNT);
	// A write that would overwrite a pending one is dropped when protected
	assign cnt_take = cnt_wr && !(async_mode && pend_ff && ctrl.async_write_disable
		&& !ext_rise);
	assign apply  = pend_ff && ext_rise;

	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	// ---------------------------------------------------------------
	// Next register values
	// ---------------------------------------------------------------
	always_comb begin
		nxt_ctrl     = ctrl_ff;
		nxt_cnt      = cnt_ff;
		nxt_per      = per_ff;
		nxt_stat     = stat_ff;
		nxt_mask     = mask_ff;
		nxt_pend     = pend_ff;
		nxt_pend_val = pend_val_ff;
		nxt_prdata   = prdata_ff;
		nxt_pslverr  = 1'b0;

		// Counting, then a due pending write, then a bus write
		if (count_tick) begin
			if (cnt_ff == per_ff) begin
				nxt_cnt = 16'h0000;
				nxt_stat[tat_pkg::TAT_BIT_MATCH] = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end
		if (apply) begin
			nxt_cnt  = pend_val_ff;
			nxt_pend = 1'b0;
		end
		if (!async_mode) begin
			nxt_pend = 1'b0;
		end

		if (wr) begin
			case (base)
				tat_pkg::TAT_ADDR_CTRL: begin
					nxt_ctrl = tat_pkg::tat_alias(ctrl_ff, wd, kind)
						& tat_pkg::TAT_CTRL_WMASK;
				end
				tat_pkg::TAT_ADDR_COUNT: begin
					if (cnt_take && async_mode) begin
						nxt_pend     = 1'b1;
						nxt_pend_val = tat_pkg::tat_alias(cnt_ff, wd, kind);
					end else if (cnt_take) begin
						nxt_cnt = tat_pkg::tat_alias(cnt_ff, wd, kind);
					end
				end
				tat_pkg::TAT_ADDR_PERIOD: begin
					nxt_per = tat_pkg::tat_alias(per_ff, wd, kind);
				end
				tat_pkg::TAT_ADDR_STATUS: begin
					// Write one to clear; a match in the same cycle wins
					nxt_stat = (stat_ff & ~(wd & tat_pkg::TAT_IRQ_WMASK))
						| {15'h0000, count_tick && (cnt_ff == per_ff)};
				end
				tat_pkg::TAT_ADDR_MASK: begin
					nxt_mask = tat_pkg::tat_alias(mask_ff, wd, kind)
						& tat_pkg::TAT_IRQ_WMASK;
				end
				default: begin
					nxt_mask = mask_ff;
				end
			endcase
		end

		// Read data is fetched in the setup phase; upper half always zero
		if (psel && !penable) begin
			nxt_prdata = 32'h00000000;
			case (base)
				tat_pkg::TAT_ADDR_CTRL:   nxt_prdata[15:0] = ctrl_ff
					| ({15'h0000, wip_rd} << tat_pkg::TAT_BIT_WIP);
				tat_pkg::TAT_ADDR_COUNT:  nxt_prdata[15:0] = cnt_ff;
				tat_pkg::TAT_ADDR_PERIOD: nxt_prdata[15:0] = per_ff;
				tat_pkg::TAT_ADDR_STATUS: nxt_prdata[15:0] = stat_ff;
				tat_pkg::TAT_ADDR_MASK:   nxt_prdata[15:0] = mask_ff;
				default:                  nxt_prdata[15:0] = 16'h0000;
			endcase
			if (!hit) begin
				nxt_prdata = 32'h00000000;
			end
			nxt_pslverr = !hit;
		end else if (acc) begin
			nxt_pslverr = pslverr_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ctrl_ff     <= tat_pkg::TAT_RST_CTRL;
			cnt_ff      <= tat_pkg::TAT_RST_COUNT;
			per_ff      <= tat_pkg::TAT_RST_PERIOD;
			stat_ff     <= tat_pkg::TAT_RST_STATUS;
			mask_ff     <= tat_pkg::TAT_RST_MASK;
			pend_ff     <= 1'b0;
			pend_val_ff <= tat_pkg::TAT_RST_COUNT;
			prdata_ff   <= 32'h00000000;
			pslverr_ff  <= 1'b0;
		end else begin
			ctrl_ff     <= nxt_ctrl;
			cnt_ff      <= nxt_cnt;
			per_ff      <= nxt_per;
			stat_ff     <= nxt_stat;
			mask_ff     <= nxt_mask;
			pend_ff     <= nxt_pend;
			pend_val_ff <= nxt_pend_val;
			prdata_ff   <= nxt_prdata;
			pslverr_ff  <= nxt_pslverr;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt
	// ---------------------------------------------------------------
	assign irq = |(stat_ff & mask_ff);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_off_no_count: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(!ctrl.on && !wr && !apply) |=> (cnt_ff == $past(cnt_ff)))
		else $error("counter moved while disabled");

	a_idle_halt: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(ctrl.stop_in_idle && idle_mode) |-> !count_tick)
		else $error("counted during idle with stop-in-idle set");

	a_wip_ignore: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(cnt_wr && async_mode && pend_ff && ctrl.async_write_disable && !ext_rise)
		|=> (pend_val_ff == $past(pend_val_ff)))
		else $error("protected pending write was overwritten");

	a_wip_sync_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(!async_mode) |=> !pend_ff)
		else $error("write pending shown outside async mode");

	a_gate_ignored: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(ctrl.clock_source_select && !ext_rise) |-> !count_tick)
		else $error("gate affected external clock counting");

	a_alias_set: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(wr && base == tat_pkg::TAT_ADDR_PERIOD && kind == tat_pkg::TAT_AL_SET)
		|=> (per_ff == ($past(per_ff) | $past(wd))))
		else $error("set alias did not or the period");

	a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
		acc |-> (prdata[31:16] == 16'h0000 && ctrl_ff[14] == 1'b0))
		else $error("unimplemented bits not zero");

	a_wrap_flag: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(count_tick && cnt_ff == per_ff && !wr && !apply)
		|=> (cnt_ff == 16'h0000 && stat_ff[tat_pkg::TAT_BIT_MATCH]))
		else $error("no wrap or match flag at period");

endmodule // tat_top
`default_nettype wire

// ==== bench/tat_top_test.sv ====
// Self-checking testbench for the type A timer top module.
// Assumes tat_pkg is compiled first; the bench is the APB master and drives all pins.
`timescale 1ns/1ps
`default_nettype none
module tat_top_test;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        idle_mode;
	logic        gate_pin;
	logic        ext_clk_pin;
	logic        irq;
	int          miscompares;
	int          checks;
	int          cycles;

	tat_top i_tat_top (
		.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .idle_mode(idle_mode), .gate_pin(gate_pin),
		.ext_clk_pin(ext_clk_pin), .irq(irq)
	);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Cuts a hung run short; the whole sequence needs about 5200 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("Checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Entered right after a rising edge; request held until pready is seen high
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, d, r, e);
	endtask

	// Read and accept any value from lo to hi; a bus error is a mismatch
	task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		logic [31:0] d;
		logic        e;
		xfer(1'b0, a, 32'h0, d, e);
		checks++;
		if (e !== 1'b0 || (d >= lo) !== 1'b1 || (d <= hi) !== 1'b1) begin
			miscompares++;
			$display("Error %s expected %h..%h seen %h", nm, lo, hi, d);
		end
	endtask

	// Disabling is followed by two quiet cycles before the next access
	task automatic off();
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h0);
		repeat (2) @(posedge clk);
	endtask

	task automatic ext_pulse(input int k);
		repeat (k) begin
			ext_clk_pin <= 1'b1;
			repeat (4) @(posedge clk);
			ext_clk_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_and_map();
		logic [31:0] d;
		logic        e;
		rchk("ctrl rst", tat_pkg::TAT_ADDR_CTRL, 32'h0, 32'h0);
		rchk("count rst", tat_pkg::TAT_ADDR_COUNT, 32'h0, 32'h0);
		rchk("period rst", tat_pkg::TAT_ADDR_PERIOD, 32'hffff, 32'hffff);
		rchk("status rst", tat_pkg::TAT_ADDR_STATUS, 32'h0, 32'h0);
		wr(tat_pkg::TAT_ADDR_CTRL, 32'hffffffff);
		rchk("ctrl wmask", tat_pkg::TAT_ADDR_CTRL, 32'hb0b6, 32'hb0b6);
		off();
		wr(tat_pkg::TAT_ADDR_PERIOD, 32'habcd00f0);
		rchk("period hi", tat_pkg::TAT_ADDR_PERIOD, 32'hf0, 32'hf0);
		wr(tat_pkg::TAT_ADDR_PERIOD + 16'h8, 32'h000f);
		rchk("alias set", tat_pkg::TAT_ADDR_PERIOD, 32'hff, 32'hff);
		wr(tat_pkg::TAT_ADDR_PERIOD + 16'h4, 32'h00f0);
		rchk("alias clr", tat_pkg::TAT_ADDR_PERIOD, 32'h0f, 32'h0f);
		wr(tat_pkg::TAT_ADDR_PERIOD + 16'hc, 32'h0003);
		rchk("alias inv", tat_pkg::TAT_ADDR_PERIOD, 32'h0c, 32'h0c);
		xfer(1'b0, 16'h0650, 32'h0, d, e);
		cmp("unmapped err", 32'h1, {31'h0, e});
		cmp("unmapped data", 32'h0, d);
		xfer(1'b1, 16'h0612, 32'h5, d, e);
		cmp("misaligned err", 32'h1, {31'h0, e});
		rchk("count kept", tat_pkg::TAT_ADDR_COUNT, 32'h0, 32'h0);
		wr(tat_pkg::TAT_ADDR_PERIOD, 32'hffff);
	endtask

	task automatic t_prescale();
		logic [31:0] v;
		logic        e;
		int          div;
		for (int c = 0; c < 4; c++) begin
			div = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
			wr(tat_pkg::TAT_ADDR_COUNT, 32'h0);
			wr(tat_pkg::TAT_ADDR_CTRL, 32'h8000 | (c << 4));
			repeat (1024) @(posedge clk);
			off();
			rchk("prescaled count", tat_pkg::TAT_ADDR_COUNT, 1024 / div, 1024 / div + 4);
		end
		xfer(1'b0, tat_pkg::TAT_ADDR_COUNT, 32'h0, v, e);
		repeat (300) @(posedge clk);
		rchk("count when off", tat_pkg::TAT_ADDR_COUNT, v, v);
	endtask

	task automatic t_match_irq();
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h0);
		wr(tat_pkg::TAT_ADDR_PERIOD, 32'h3);
		wr(tat_pkg::TAT_ADDR_MASK, 32'h1);
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h8000);
		repeat (20) @(posedge clk);
		cmp("irq on match", 32'h1, {31'h0, irq});
		rchk("count wraps", tat_pkg::TAT_ADDR_COUNT, 32'h0, 32'h3);
		off();
		rchk("status set", tat_pkg::TAT_ADDR_STATUS, 32'h1, 32'h1);
		wr(tat_pkg::TAT_ADDR_STATUS, 32'h1);
		rchk("status clear", tat_pkg::TAT_ADDR_STATUS, 32'h0, 32'h0);
		cmp("irq cleared", 32'h0, {31'h0, irq});
		wr(tat_pkg::TAT_ADDR_MASK, 32'h0);
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h8000);
		repeat (20) @(posedge clk);
		off();
		cmp("irq masked", 32'h0, {31'h0, irq});
		rchk("status masked", tat_pkg::TAT_ADDR_STATUS, 32'h1, 32'h1);
		wr(tat_pkg::TAT_ADDR_STATUS, 32'h1);
		wr(tat_pkg::TAT_ADDR_PERIOD, 32'hffff);
	endtask

	task automatic t_idle_gate();
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h0);
		idle_mode <= 1'b1;
		wr(tat_pkg::TAT_ADDR_CTRL, 32'ha000);
		repeat (100) @(posedge clk);
		rchk("idle halt", tat_pkg::TAT_ADDR_COUNT, 32'h0, 32'h0);
		idle_mode <= 1'b0;
		repeat (100) @(posedge clk);
		off();
		rchk("idle left", tat_pkg::TAT_ADDR_COUNT, 32'd100, 32'd106);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h0);
		idle_mode <= 1'b1;
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h8000);
		repeat (100) @(posedge clk);
		off();
		idle_mode <= 1'b0;
		rchk("idle runs", tat_pkg::TAT_ADDR_COUNT, 32'd100, 32'd106);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h0);
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h8080);
		repeat (50) @(posedge clk);
		rchk("gate low", tat_pkg::TAT_ADDR_COUNT, 32'h0, 32'h0);
		gate_pin <= 1'b1;
		repeat (50) @(posedge clk);
		gate_pin <= 1'b0;
		repeat (4) @(posedge clk);
		off();
		rchk("gate high", tat_pkg::TAT_ADDR_COUNT, 32'd48, 32'd54);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h0);
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h8086);
		ext_pulse(5);
		off();
		rchk("gate ignored", tat_pkg::TAT_ADDR_COUNT, 32'd5, 32'd5);
	endtask

	task automatic t_async_write();
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h1002);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h1234);
		rchk("pending set", tat_pkg::TAT_ADDR_CTRL, 32'h1802, 32'h1802);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h5555);
		ext_pulse(1);
		rchk("pending done", tat_pkg::TAT_ADDR_CTRL, 32'h1002, 32'h1002);
		rchk("second ignored", tat_pkg::TAT_ADDR_COUNT, 32'h1234, 32'h1234);
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h0002);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h1111);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h2222);
		ext_pulse(1);
		rchk("back to back", tat_pkg::TAT_ADDR_COUNT, 32'h2222, 32'h2222);
		wr(tat_pkg::TAT_ADDR_CTRL, 32'h1006);
		wr(tat_pkg::TAT_ADDR_COUNT, 32'h0042);
		rchk("sync no pend", tat_pkg::TAT_ADDR_CTRL, 32'h1006, 32'h1006);
		rchk("sync write", tat_pkg::TAT_ADDR_COUNT, 32'h0042, 32'h0042);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		miscompares = 0;
		checks      = 0;
		cycles      = 0;
		arst_n      = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 16'h0000;
		pwdata      = 32'h0000_0000;
		idle_mode   = 1'b0;
		gate_pin    = 1'b0;
		ext_clk_pin = 1'b0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset_and_map();
		t_prescale();
		t_match_irq();
		t_idle_gate();
		t_async_write();
		conclude();
	end

endmodule // tat_top_test
`default_nettype wire
